/* slave_fifo_waveform_ecc.sv */
// Endpoint RAM, slave FIFO port, waveform engine and ECC generator
`timescale 1ns/10ps
`include "sfw_params.svh"
// ----------------------------------------------------------------------------
// What this block does
// - Eight 512-byte RAM blocks serve as FIFOs
// - Blocks are 256x16, reassigned without copying
// - Single port for USB, dual for I/O
// - Endpoints use one to four buffers
// - Waveform engine drives FIFO select in master
// - Slave accepts clock, select and strobes
// - Per-endpoint byte or word width on output
// - Async strobes direct, sync strobes qualify clock
// - Chip select gates all slave strobes
// - Bit picks 30 or 48 MHz clock
// - External interface clock 5 to 48 MHz
// - Clock out drive enable and inversion bits
// - Six controls, nine address, six ready
// - Step sets controls, waits, advances pointers
// - Ready inputs tested for step branching
// - Controls may change every interface clock
// - Address outputs index a 512-byte block
// - 32-bit transaction count, stall, decrement
// - Mode clear: ECC per 256-byte half
// - Mode set: one ECC over 512 bytes
// - Restart begins ECC; results then freeze
// - ECC corrects single, detects double errors
// ----------------------------------------------------------------------------
module slave_fifo_waveform_ecc
  import sfw_pkg::*;
(
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_iface_clk,
  input  wire logic         i_usb_req,
  input  wire logic         i_usb_we,
  input  wire logic [10:0]  i_usb_addr,
  input  wire logic [15:0]  i_usb_wdata,
  output logic              o_usb_ack,
  output logic              o_usb_busy,
  output logic [15:0]       o_usb_rdata,
  input  wire logic [7:0]   i_block_owner_io,
  input  wire logic         i_master_mode,
  input  wire logic         i_async_mode,
  input  wire logic [3:0]   i_ep_word_wide,
  input  wire logic [3:0]   i_ep_dir_in,
  input  wire logic [11:0]  i_ep_base_block,
  input  wire logic [7:0]   i_ep_buf_count,
  input  wire logic [1:0]   i_wave_fifo_sel,
  input  wire logic [199:0] i_wave_prog,
  input  wire logic [31:0]  i_transaction_count,
  input  wire logic         i_wave_start,
  output logic              o_wave_done,
  input  wire logic         i_ecc_block_mode,
  input  wire logic         i_ecc_restart,
  output logic              o_ecc_done,
  input  wire logic         i_iface_clock_source_sel,
  input  wire logic         i_int_clock_48_sel,
  input  wire logic         i_iface_clk_out_en,
  input  wire logic         i_iface_clk_invert,
  output logic              o_int_clock_48_sel,
  output logic              o_interface_clock_pin,
  output logic              o_interface_clock_oe_n,
  input  wire logic         i_slave_chip_select_n,
  input  wire logic         i_slave_read_strobe,
  input  wire logic         i_slave_write_strobe,
  input  wire logic         i_slave_output_enable,
  input  wire logic         i_packet_end_strobe,
  input  wire logic [1:0]   i_fifo_select_address,
  output logic [1:0]        o_fifo_select_address,
  output logic              o_fifo_select_oe_n,
  input  wire logic [15:0]  i_fd_in,
  output logic [15:0]       o_fd_out,
  output logic              o_fd_oe_n,
  input  wire logic [5:0]   i_ready_in,
  output logic [5:0]        o_waveform_control_out,
  output logic [8:0]        o_waveform_address_out,
  output logic              o_fifo_avail,
  output logic [31:0]       o_transaction_count,
  output logic [23:0]       o_ecc_result_first,
  output logic [23:0]       o_ecc_result_second
);
  localparam int CFG_W = 273;
  localparam int PIN_W = 29;
  // ----------------------------------------------------------------------------
  // Reset release and crossings into the interface clock
  // ----------------------------------------------------------------------------
  logic [1:0]       irst_r;
  logic             irst_b;
  logic [CFG_W-1:0] cfg_s1_r, cfg_s2_r;
  logic [PIN_W-1:0] pin_s1_r, pin_s2_r;
  logic [2:0]       tgl_s1_r, tgl_s2_r, tgl_d_r;
  logic             start_tgl_r, rst_tgl_r, req_tgl_r, ack_tgl_r;
  logic [27:0]      req_hold_r;
  wave_state_t      wave_st_r;
  ecc_phase_t       ecc_ph_r;
  logic             req_evt_pend_r;
  always_ff @(posedge i_iface_clk or negedge i_rst_b)
  begin
    if (!i_rst_b) irst_r <= 2'b00;
    else          irst_r <= {irst_r[0], 1'b1};
  end
  assign irst_b = irst_r[1];
  // Config is quasi-static: software changes it only while the link is idle
  always_ff @(posedge i_iface_clk or negedge irst_b)
  begin
    if (!irst_b)
    begin
      cfg_s1_r <= '0;
      cfg_s2_r <= '0;
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      tgl_s1_r <= 3'h0;
      tgl_s2_r <= 3'h0;
      tgl_d_r  <= 3'h0;
    end
    else
    begin
      cfg_s1_r <= {i_block_owner_io, i_master_mode, i_async_mode, i_ep_word_wide,
                   i_ep_dir_in, i_ep_base_block, i_ep_buf_count, i_wave_fifo_sel,
                   i_wave_prog, i_transaction_count, i_ecc_block_mode};
      cfg_s2_r <= cfg_s1_r;
      pin_s1_r <= {i_slave_chip_select_n, i_slave_read_strobe, i_slave_write_strobe,
                   i_slave_output_enable, i_packet_end_strobe, i_fifo_select_address,
                   i_fd_in, i_ready_in};
      pin_s2_r <= pin_s1_r;
      tgl_s1_r <= {req_tgl_r, rst_tgl_r, start_tgl_r};
      tgl_s2_r <= tgl_s1_r;
      tgl_d_r  <= tgl_s2_r;
    end
  end
  logic [7:0]   owner_io;
  logic         master, async_m, ecc_mode, cs_n_s, rd_s, wr_s, oe_s, pe_s;
  logic [3:0]   word_wide, dir_in;
  logic [11:0]  base_blk;
  logic [7:0]   buf_cnt;
  logic [1:0]   wave_sel, sel_s, ep;
  logic [199:0] prog;
  logic [31:0]  tc_load;
  logic [15:0]  fd_s;
  logic [5:0]   rdy_s;
  assign {owner_io, master, async_m, word_wide, dir_in, base_blk, buf_cnt, wave_sel,
          prog, tc_load, ecc_mode} = cfg_s2_r;
  assign {cs_n_s, rd_s, wr_s, oe_s, pe_s, sel_s, fd_s, rdy_s} = pin_s2_r;
  logic start_evt, restart_evt, req_evt;
  assign start_evt   = tgl_s2_r[0] ^ tgl_d_r[0];
  assign restart_evt = tgl_s2_r[1] ^ tgl_d_r[1];
  assign req_evt     = tgl_s2_r[2] ^ tgl_d_r[2];
  // ----------------------------------------------------------------------------
  // System clock side: requests out, status back
  // ----------------------------------------------------------------------------
  logic [2:0] back_s1_r, back_s2_r;
  logic       ack_d_r;
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      start_tgl_r        <= 1'b0;
      rst_tgl_r          <= 1'b0;
      req_tgl_r          <= 1'b0;
      req_hold_r         <= '0;
      back_s1_r          <= 3'h0;
      back_s2_r          <= 3'h0;
      ack_d_r            <= 1'b0;
      o_int_clock_48_sel <= 1'b0;
    end
    else
    begin
      o_int_clock_48_sel <= i_int_clock_48_sel;
      if (i_wave_start)  start_tgl_r <= ~start_tgl_r;
      if (i_ecc_restart) rst_tgl_r   <= ~rst_tgl_r;
      // Address and data stay held until the interface side answers
      if (i_usb_req && !o_usb_busy)
      begin
        req_tgl_r  <= ~req_tgl_r;
        req_hold_r <= {i_usb_we, i_usb_addr, i_usb_wdata};
      end
      back_s1_r <= {ack_tgl_r, wave_st_r == WAVE_DONE, ecc_ph_r == ECC_FROZEN};
      back_s2_r <= back_s1_r;
      ack_d_r   <= back_s2_r[2];
    end
  end
  assign o_usb_busy  = req_tgl_r ^ ack_d_r;
  assign o_usb_ack   = back_s2_r[2] ^ ack_d_r;
  assign o_wave_done = back_s2_r[1];
  assign o_ecc_done  = back_s2_r[0];
  // ----------------------------------------------------------------------------
  // Interface clock pin
  // ----------------------------------------------------------------------------
  assign o_interface_clock_pin  = i_iface_clk ^ i_iface_clk_invert;
  // Driven only when the clock is internal; external source must run first
  assign o_interface_clock_oe_n = ~(~i_iface_clock_source_sel & i_iface_clk_out_en);
  // ----------------------------------------------------------------------------
  // Endpoint RAM and FIFO pointers
  // ----------------------------------------------------------------------------
  logic [15:0] ram_r [`SFW_BLOCKS*`SFW_BLOCK_WORDS];
  logic [8:0]  ptr_r [`SFW_NUM_EP];
  logic [1:0]  bufi_r [`SFW_NUM_EP];
  logic [2:0]  cur_blk;
  logic [10:0] cur_wa;
  logic        word_m, xfer, xfer_wr, pkt_end, wrap;
  logic [8:0]  ptr_nxt;
  logic [15:0] rd_word;
  logic [7:0]  lane_byte, ecc_byte;
  assign ep       = master ? wave_sel : sel_s;
  assign cur_blk  = 3'(base_blk[ep*3 +: 3] + {1'b0, bufi_r[ep]});
  assign cur_wa   = {cur_blk, ptr_r[ep][8:1]};
  assign word_m   = word_wide[ep];
  assign rd_word  = ram_r[cur_wa];
  assign lane_byte = ptr_r[ep][0] ? rd_word[15:8] : rd_word[7:0];
  // Storage the serial engine still owns ignores I/O read and write strobes, but its data still reaches the FD pins
  assign o_fifo_avail = owner_io[cur_blk];
  assign ptr_nxt  = 9'(ptr_r[ep] + (word_m ? 9'h002 : 9'h001));
  assign wrap     = (ptr_nxt == 9'h000);
  // Slave strobes
  logic rd_d_r, wr_d_r, pe_d_r, cs, s_rd, s_wr;
  always_ff @(posedge i_iface_clk or negedge irst_b)
  begin
    if (!irst_b)
    begin
      rd_d_r <= 1'b0;
      wr_d_r <= 1'b0;
      pe_d_r <= 1'b0;
    end
    else
    begin
      rd_d_r <= rd_s;
      wr_d_r <= wr_s;
      pe_d_r <= pe_s;
    end
  end
  assign cs   = ~cs_n_s & ~master;
  assign s_rd = cs & rd_s & (async_m ? ~rd_d_r : 1'b1) & o_fifo_avail;
  assign s_wr = cs & wr_s & (async_m ? ~wr_d_r : 1'b1) & o_fifo_avail;
  assign pkt_end = cs & pe_s & ~pe_d_r;
  // Waveform engine
  logic [2:0]  step_r;
  logic [31:0] tc_r;
  logic [8:0]  adr_r;
  logic [24:0] cur;
  logic        match, proceed, w_xfer;
  assign cur     = prog[step_r*`SFW_STEP_W +: `SFW_STEP_W];
  assign match   = (rdy_s & cur[`SFW_STEP_MSK_LSB +: 6]) == cur[`SFW_STEP_VAL_LSB +: 6];
  // Stalls on storage not yet handed over, so it cannot under or overflow
  assign proceed = (wave_st_r == WAVE_RUN) && match
                   && (!cur[`SFW_STEP_ADVF] || o_fifo_avail);
  assign w_xfer  = proceed && cur[`SFW_STEP_ADVF];
  assign xfer_wr = master ? (w_xfer && dir_in[ep]) : s_wr;
  assign xfer    = master ? w_xfer : (s_wr || s_rd);
  always_ff @(posedge i_iface_clk or negedge irst_b)
  begin
    if (!irst_b)
    begin
      wave_st_r <= WAVE_IDLE;
      step_r    <= 3'h0;
      tc_r      <= 32'h0000_0000;
      adr_r     <= 9'h000;
    end
    else
    begin
      case (wave_st_r)
        WAVE_IDLE, WAVE_DONE:
        begin
          if (start_evt && master)
          begin
            wave_st_r <= WAVE_RUN;
            step_r    <= 3'h0;
            tc_r      <= tc_load;
          end
        end
        WAVE_RUN:
        begin
          if (!match && cur[`SFW_STEP_BRANCH])
            step_r <= cur[`SFW_STEP_ALT_LSB +: 3];
          else if (proceed)
          begin
            if (cur[`SFW_STEP_ADVA]) adr_r <= 9'(adr_r + 9'h001);
            if (cur[`SFW_STEP_LAST])
            begin
              tc_r   <= 32'(tc_r - 32'h0000_0001);
              step_r <= 3'h0;
              if (tc_r == 32'h0000_0001) wave_st_r <= WAVE_DONE;
            end
            else
              step_r <= 3'(step_r + 3'h1);
          end
        end
        default: wave_st_r <= WAVE_IDLE;
      endcase
    end
  end
  // Control outputs register the step every clock, so edges can come per cycle
  always_ff @(posedge i_iface_clk or negedge irst_b)
  begin
    if (!irst_b) o_waveform_control_out <= `SFW_CTL_IDLE;
    else if (wave_st_r == WAVE_RUN) o_waveform_control_out <= cur[5:0];
    else o_waveform_control_out <= `SFW_CTL_IDLE;
  end
  assign o_waveform_address_out = adr_r;
  assign o_transaction_count    = tc_r;
  assign o_fifo_select_address  = wave_sel;
  assign o_fifo_select_oe_n     = ~master;
  // Pointer advance, buffer rotation and RAM ports
  logic usb_go, usb_we;
  assign usb_go = req_evt_pend_r && !(xfer_wr && req_hold_r[27]);
  assign usb_we = req_hold_r[27];
  genvar g;
  generate
    for (g = 0; g < `SFW_NUM_EP; g++)
    begin : g_ep
      always_ff @(posedge i_iface_clk or negedge irst_b)
      begin
        if (!irst_b)
        begin
          ptr_r[g]  <= 9'h000;
          bufi_r[g] <= 2'h0;
        end
        else if (ep == 2'(g) && ((xfer && o_fifo_avail) || pkt_end))
        begin
          ptr_r[g] <= pkt_end ? 9'h000 : ptr_nxt;
          if (pkt_end || wrap)
            bufi_r[g] <= (bufi_r[g] == buf_cnt[g*2 +: 2]) ? 2'h0 : 2'(bufi_r[g] + 2'h1);
        end
      end
    end
  endgenerate
  // One write port; the transfer takes it first, a pending write request waits
  always_ff @(posedge i_iface_clk)
  begin
    if (xfer_wr)
    begin
      if (word_m || !ptr_r[ep][0]) ram_r[cur_wa][7:0]  <= word_m ? fd_s[7:0] : fd_s[7:0];
      if (word_m ||  ptr_r[ep][0]) ram_r[cur_wa][15:8] <= word_m ? fd_s[15:8] : fd_s[7:0];
    end
    else if (usb_go && usb_we)
      ram_r[req_hold_r[26:16]] <= req_hold_r[15:0];
  end
  // The request side is one access at a time: single port for USB
  always_ff @(posedge i_iface_clk or negedge irst_b)
  begin
    if (!irst_b)
    begin
      req_evt_pend_r <= 1'b0;
      ack_tgl_r      <= 1'b0;
      o_usb_rdata    <= 16'h0000;
    end
    else
    begin
      if (req_evt) req_evt_pend_r <= 1'b1;
      else if (usb_go) req_evt_pend_r <= 1'b0;
      if (usb_go)
      begin
        ack_tgl_r   <= ~ack_tgl_r;
        o_usb_rdata <= ram_r[req_hold_r[26:16]];
      end
    end
  end
  // Data pins
  always_ff @(posedge i_iface_clk or negedge irst_b)
  begin
    if (!irst_b)
    begin
      o_fd_out  <= 16'h0000;
      o_fd_oe_n <= 1'b1;
    end
    else
    begin
      o_fd_out  <= word_m ? rd_word : {8'h00, lane_byte};
      o_fd_oe_n <= ~(master ? (wave_st_r == WAVE_RUN && !dir_in[ep])
                            : (cs && oe_s));
    end
  end
  // ----------------------------------------------------------------------------
  // ECC generator
  // ----------------------------------------------------------------------------
  logic [9:0]  bcnt_r;
  logic [17:0] line_r, line_nxt;
  logic [5:0]  col_r, col_nxt;
  logic        ecc_feed, last_b;
  assign ecc_byte = xfer_wr ? fd_s[7:0] : lane_byte;
  // Word-wide traffic is not covered by the code
  assign ecc_feed = xfer && !word_m && ecc_ph_r != ECC_FROZEN;
  assign last_b   = ecc_mode ? (bcnt_r == `SFW_ECC_FULL_END)
                             : (bcnt_r[7:0] == 8'(`SFW_ECC_HALF_END));
  always_comb
  begin
    logic p;
    p = ^ecc_byte;
    line_nxt = line_r;
    for (int k = 0; k < 9; k++)
    begin
      line_nxt[2*k+1] = line_r[2*k+1] ^ (p & bcnt_r[k]);
      line_nxt[2*k]   = line_r[2*k]   ^ (p & ~bcnt_r[k]);
    end
    col_nxt = col_r ^ {^ecc_byte[7:4], ^ecc_byte[3:0], ^{ecc_byte[7:6], ecc_byte[3:2]},
                       ^{ecc_byte[5:4], ecc_byte[1:0]},
                       ^{ecc_byte[7], ecc_byte[5], ecc_byte[3], ecc_byte[1]},
                       ^{ecc_byte[6], ecc_byte[4], ecc_byte[2], ecc_byte[0]}};
    if (!ecc_mode && !bcnt_r[8]) line_nxt[17:16] = 2'b11;
    if (!ecc_mode) line_nxt[17:16] = 2'b11;
  end
  always_ff @(posedge i_iface_clk or negedge irst_b)
  begin
    if (!irst_b)
    begin
      ecc_ph_r            <= ECC_FIRST;
      bcnt_r              <= 10'h000;
      line_r              <= 18'h00000;
      col_r               <= 6'h00;
      o_ecc_result_first  <= `SFW_ECC_RESET;
      o_ecc_result_second <= `SFW_ECC_RESET;
    end
    else if (restart_evt)
    begin
      ecc_ph_r            <= ECC_FIRST;
      bcnt_r              <= 10'h000;
      line_r              <= 18'h00000;
      col_r               <= 6'h00;
      o_ecc_result_first  <= `SFW_ECC_RESET;
      o_ecc_result_second <= `SFW_ECC_RESET;
    end
    else if (ecc_feed)
    begin
      bcnt_r <= 10'(bcnt_r + 10'h001);
      if (last_b)
      begin
        line_r <= 18'h00000;
        col_r  <= 6'h00;
        if (ecc_ph_r == ECC_FIRST)
        begin
          o_ecc_result_first <= {col_nxt, line_nxt[17:16], line_nxt[15:0]};
          ecc_ph_r <= ecc_mode ? ECC_FROZEN : ECC_SECOND;
        end
        else
        begin
          o_ecc_result_second <= {col_nxt, line_nxt[17:16], line_nxt[15:0]};
          ecc_ph_r <= ECC_FROZEN;
        end
      end
      else
      begin
        line_r <= line_nxt;
        col_r  <= col_nxt;
      end
    end
  end
  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  AST_NO_IO_ON_USB_BLOCK: assert property (@(posedge i_iface_clk) disable iff (!irst_b)
    xfer_wr |-> owner_io[cur_blk]) else $error("transfer into block owned by engine");
  AST_CS_GATES: assert property (@(posedge i_iface_clk) disable iff (!irst_b)
    cs_n_s |-> !s_rd && !s_wr && !pkt_end) else $error("strobe acted without select");
  AST_ASYNC_EDGE: assert property (@(posedge i_iface_clk) disable iff (!irst_b)
    (async_m && s_wr) |=> !s_wr) else $error("async write taken twice");
  AST_FIFOSEL: assert property (@(posedge i_iface_clk) disable iff (!irst_b)
    master |-> !o_fifo_select_oe_n && o_fifo_select_address == wave_sel)
    else $error("fifo select not driven in master mode");
  AST_CTL_STEP: assert property (@(posedge i_iface_clk) disable iff (!irst_b)
    (wave_st_r == WAVE_RUN) |=> o_waveform_control_out == $past(cur[5:0]))
    else $error("control outputs lag the step");
  AST_COUNT_DEC: assert property (@(posedge i_iface_clk) disable iff (!irst_b)
    (proceed && cur[`SFW_STEP_LAST] && !restart_evt) |=> tc_r == $past(tc_r) - 32'h1)
    else $error("transaction count not decremented");
  AST_STALL: assert property (@(posedge i_iface_clk) disable iff (!irst_b)
    (wave_st_r == WAVE_RUN && match && cur[`SFW_STEP_ADVF] && !o_fifo_avail)
    |=> $stable(step_r) && $stable(adr_r)) else $error("engine ran on unavailable block");
  AST_ADDR_INC: assert property (@(posedge i_iface_clk) disable iff (!irst_b)
    (proceed && cur[`SFW_STEP_ADVA]) |=> adr_r == 9'($past(adr_r) + 9'h001))
    else $error("address did not advance");
  AST_ECC_FROZEN: assert property (@(posedge i_iface_clk) disable iff (!irst_b)
    (ecc_ph_r == ECC_FROZEN && !restart_evt) |=> $stable(o_ecc_result_first)
    && $stable(o_ecc_result_second)) else $error("ECC changed while frozen");
  AST_ECC_ONE: assert property (@(posedge i_iface_clk) disable iff (!irst_b)
    (ecc_mode && !restart_evt) |=> $stable(o_ecc_result_second))
    else $error("second ECC written in 512-byte mode");
  COV_WAVE_DONE: cover property (@(posedge i_iface_clk) disable iff (!irst_b)
    wave_st_r == WAVE_RUN ##1 wave_st_r == WAVE_DONE);
  COV_ECC_TWO: cover property (@(posedge i_iface_clk) disable iff (!irst_b)
    ecc_ph_r == ECC_SECOND ##1 ecc_ph_r == ECC_FROZEN);
  COV_SLAVE_RD: cover property (@(posedge i_iface_clk) disable iff (!irst_b) s_rd && wrap);
endmodule

/* sfw_params.svh */
// Constants for the slave FIFO, waveform engine and ECC block
`ifndef SFW_PARAMS_SVH
`define SFW_PARAMS_SVH
// ----------------------------------------------------------------------------
// Storage geometry
// ----------------------------------------------------------------------------
`define SFW_BLOCKS        8
`define SFW_BLOCK_WORDS   256
`define SFW_WORD_W        16
`define SFW_BLOCK_BYTES   10'h200
`define SFW_RAM_AW        11
`define SFW_NUM_EP        4
// ----------------------------------------------------------------------------
// Waveform engine
// ----------------------------------------------------------------------------
`define SFW_NUM_CTL       6
`define SFW_NUM_RDY       6
`define SFW_NUM_ADR       9
`define SFW_NUM_STEPS     8
`define SFW_STEP_W        25
`define SFW_STEP_CTL_LSB  0
`define SFW_STEP_MSK_LSB  6
`define SFW_STEP_VAL_LSB  12
`define SFW_STEP_ADVF     18
`define SFW_STEP_ADVA     19
`define SFW_STEP_ALT_LSB  20
`define SFW_STEP_BRANCH   23
`define SFW_STEP_LAST     24
`define SFW_CTL_IDLE      6'h00
// ----------------------------------------------------------------------------
// ECC
// ----------------------------------------------------------------------------
`define SFW_ECC_W         24
`define SFW_ECC_HALF_END  10'h0FF
`define SFW_ECC_FULL_END  10'h1FF
`define SFW_ECC_RESET     24'h000000
// ----------------------------------------------------------------------------
// Interface clock limits, in MHz, and control edge spacing, in ps
// ----------------------------------------------------------------------------
`define SFW_INT_CLK_LO_MHZ 30
`define SFW_INT_CLK_HI_MHZ 48
`define SFW_EXT_CLK_MIN_MHZ 5
`define SFW_EXT_CLK_MAX_MHZ 48
`define SFW_CTL_EDGE_PS   20800
`endif

/* sfw_pkg.sv */
// Types shared by the slave FIFO, waveform engine and ECC block
package sfw_pkg;
  typedef enum logic [1:0] {
    WAVE_IDLE = 2'b00,
    WAVE_RUN  = 2'b01,
    WAVE_DONE = 2'b10
  } wave_state_t;
  typedef enum logic [1:0] {
    ECC_FIRST  = 2'b00,
    ECC_SECOND = 2'b01,
    ECC_FROZEN = 2'b10
  } ecc_phase_t;
endpackage

/* far_writer.sv */
// Far-side logic that writes byte frames into the slave FIFO
`timescale 1ns/10ps
module far_writer (
  input  wire logic       i_clk,
  input  wire logic       i_go,
  input  wire logic       i_sel,
  input  wire logic [7:0] i_byte,
  output logic            o_busy,
  output logic            o_cs_n,
  output logic            o_wr,
  output logic            o_oe,
  output logic [15:0]     o_fd
);
  int n = 0;
  initial {o_cs_n, o_wr, o_oe, o_fd} = {1'h1, 1'h0, 1'h0, 16'h0000};
  assign o_busy = (n != 0);
  // Frame of 256 clock-qualified bytes; released bus toggles so stale data never looks valid
  always @(negedge i_clk)
  begin
    if (i_go && n == 0)
      n = 256;
    else if (n != 0)
      n = n - 1;
    o_cs_n <= !(i_sel && n != 0);
    o_wr   <= (n != 0);
    o_oe   <= 1'h0;
    // First byte of a frame has bit 0 flipped, so the check code sees a nonzero pattern
    o_fd   <= (n != 0) ? {8'h00, i_byte ^ {7'h00, n == 256}} : ~o_fd;
  end
endmodule

/* slave_fifo_waveform_ecc_test.sv */
// Self-checking bench for the slave FIFO and ECC block
`timescale 1ns/10ps
module slave_fifo_waveform_ecc_test;
  logic clk = 0, ifc = 0, rst_b = 0, req = 0, we = 0, go = 0, sel = 0, em = 0, er = 0;
  logic [10:0] adr = 11'h000;
  logic [15:0] wd = 16'h0000, fd, rd;
  logic [7:0]  by = 8'h00;
  logic        cs_n, wr, oe, wbusy, ack, busy, edone, pin, pin_oe_n, s48;
  logic [23:0] e1, e2;
  logic        mm = 0, am = 0, ws = 0, csrc = 0, s48i = 1, oen = 1, inv = 1, wdone, fsoe;
  logic [3:0]  ww = 4'h0, di = 4'hF;
  logic [7:0]  owner = 8'h01, bc = 8'h00;
  logic [11:0] bb = 12'h000;
  logic [8:0]  wadr;
  logic [31:0] tc = 32'h0000_0004, tcnt;
  // One step: control 2A, advance FIFO and address, ends each transaction
  logic [199:0] prog = 200'h10C002A;
  int          fails = 0, tests_run = 0, cyc = 0;
  always #10 clk = ~clk;
  initial #7 forever #40 ifc = ~ifc;
  far_writer far (.i_clk(ifc), .i_go(go), .i_sel(sel), .i_byte(by), .o_busy(wbusy),
    .o_cs_n(cs_n), .o_wr(wr), .o_oe(oe), .o_fd(fd));
  slave_fifo_waveform_ecc dut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_iface_clk(ifc), .i_usb_req(req), .i_usb_we(we),
    .i_usb_addr(adr), .i_usb_wdata(wd), .o_usb_ack(ack), .o_usb_busy(busy), .o_usb_rdata(rd),
    .i_block_owner_io(owner), .i_master_mode(mm), .i_async_mode(am),
    .i_ep_word_wide(ww), .i_ep_dir_in(di), .i_ep_base_block(bb),
    .i_ep_buf_count(bc), .i_wave_fifo_sel(2'h0), .i_wave_prog(prog),
    .i_transaction_count(tc), .i_wave_start(ws), .o_wave_done(wdone),
    .i_ecc_block_mode(em), .i_ecc_restart(er), .o_ecc_done(edone),
    .i_iface_clock_source_sel(csrc), .i_int_clock_48_sel(s48i), .i_iface_clk_out_en(oen),
    .i_iface_clk_invert(inv), .o_int_clock_48_sel(s48), .o_interface_clock_pin(pin),
    .o_interface_clock_oe_n(pin_oe_n), .i_slave_chip_select_n(cs_n),
    .i_slave_read_strobe(1'h0), .i_slave_write_strobe(wr), .i_slave_output_enable(oe),
    .i_packet_end_strobe(1'h0), .i_fifo_select_address(2'h0), .o_fifo_select_address(),
    .o_fifo_select_oe_n(fsoe), .i_fd_in(fd), .o_fd_out(), .o_fd_oe_n(), .i_ready_in(6'h00),
    .o_waveform_control_out(), .o_waveform_address_out(wadr), .o_fifo_avail(),
    .o_transaction_count(tcnt), .o_ecc_result_first(e1), .o_ecc_result_second(e2));
  task chk(input logic [23:0] got, input logic [23:0] exp);
  begin
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task usb(input logic w, input logic [10:0] a, input logic [15:0] d);
    int k;
  begin
    @(negedge clk) {req, we, adr, wd} = {1'h1, w, a, d};
    @(negedge clk) req = 0;
    for (k = 0; k < 100 && ack !== 1'h1; k++)
      @(negedge clk);
    chk(ack, 24'h1);
  end
  endtask
  // Bounded waits: a stuck far side would otherwise hang here
  task burst(input logic s, input logic [7:0] b);
    int k;
  begin
    @(negedge clk) {go, sel, by} = {1'h1, s, b};
    for (k = 0; k < 50 && !wbusy; k++)
      @(negedge clk);
    go = 0;
    for (k = 0; k < 2000 && wbusy; k++)
      @(negedge clk);
    repeat (40) @(negedge clk);
  end
  endtask
  task restart;
  begin
    @(negedge clk) er = 1;
    @(negedge clk) er = 0;
    repeat (40) @(negedge clk);
  end
  endtask
  task report_and_stop;
  begin
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst_b = 1;
    repeat (20) @(negedge clk);
    chk(s48, 24'h1);
    chk({pin_oe_n, pin}, {1'h0, ~ifc});
    {csrc, inv} = 2'b10;
    @(negedge clk) chk({pin_oe_n, pin}, {1'h1, ifc});
    usb(1, 11'h501, 16'hA5C3);
    usb(1, 11'h502, 16'h3C5A);
    usb(0, 11'h501, 16'h0000);
    chk(rd, 24'h00A5C3);
    $display("clock and storage test done");
    restart;
    burst(0, 8'h00);
    burst(1, 8'h00);
    chk(e1, 24'h575555);
    chk(edone, 24'h0);
    burst(1, 8'h00);
    chk(e2, 24'h575555);
    chk(edone, 24'h1);
    burst(1, 8'hFF);
    chk({e1[11:0], e2[11:0]}, 24'h555555);
    chk({e1[23:12], e2[23:12]}, 24'h575575);
    em = 1;
    restart;
    chk(e1, 24'h000000);
    chk(edone, 24'h0);
    burst(1, 8'h00);
    chk(edone, 24'h0);
    burst(1, 8'h00);
    chk(edone, 24'h1);
    chk(e1, 24'h030000);
    chk(e2, 24'h000000);
    $display("ecc test done");
    mm = 1;
    repeat (20) @(negedge clk);
    ws = 1;
    @(negedge clk) ws = 0;
    repeat (60) @(negedge clk);
    chk(wdone, 24'h1);
    chk(tcnt[23:0], 24'h000000);
    chk({15'h0000, wadr}, 24'h000004);
    chk(fsoe, 24'h0);
    $display("waveform test done");
    report_and_stop;
  end
endmodule
